// ---- common/mbs_map.vh ----
// Constants for the serial-link function handler: function codes, exception codes,
// coil and holding register layout, frame lengths and the CRC-16 generator.
// Included by the handler; holds definitions only.
`ifndef MBS_MAP_VH
`define MBS_MAP_VH

// Function codes handled here, and the exception marker added to a failed one.
`define MBS_FN_READ_COILS 8'h01
`define MBS_FN_READ_REGS 8'h03
`define MBS_FN_WRITE_COIL 8'h05
`define MBS_FN_EXC_FLAG 8'h80

// Exception codes.
`define MBS_EXC_BAD_FUNC 8'h01
`define MBS_EXC_BAD_ADDR 8'h02
`define MBS_EXC_BAD_DATA 8'h03

// Broadcast slave address.
`define MBS_BCAST_ADDR 8'h00

// Coils: numbers 1..86, link addresses 0..85.
`define MBS_COIL_COUNT 7'h56
`define MBS_COIL_COUNT_W 17'h00056
`define MBS_COIL_READ_MAX 16'h001E
`define MBS_COIL_ON_DATA 16'hFF00
`define MBS_COIL_OFF_DATA 16'h0000
`define MBS_COIL_RESET 86'h0

// Holding register numbers (link address is one less).
`define MBS_REG_TRIP_CAUSE 17'h00012
`define MBS_REG_TRIP_STATE 17'h00013
`define MBS_REG_TRIP_FREQ_HI 17'h00014
`define MBS_REG_TRIP_FREQ_LO 17'h00015
`define MBS_REG_TRIP_CURRENT 17'h00016
`define MBS_REG_TRIP_DC_BUS 17'h00017
`define MBS_REG_READ_MAX 16'h0006

// Every query handled here is exactly eight bytes long.
`define MBS_QUERY_LEN 4'h8

// CRC-16, generator x16+x15+x2+1 in reflected form, preset to all ones.
`define MBS_CRC_INIT 16'hFFFF
`define MBS_CRC_POLY 16'hA001

`endif

// ---- logic/mbs_func.v ----
// Function handler of a serial-link slave: read coils, read holding registers,
// write single coil, with CRC-16 check on queries and CRC-16 generation on replies.
// Assumes a byte receiver on the same clock that delivers query bytes and marks the
// end of a frame after the silent interval, and a byte transmitter with a ready input.
//
// Behaviour
// - Function 01h returns on/off states of the requested consecutive coils.
// - Coil read of zero or 31 or more coils answers exception 03h.
// - Read replies carry a byte count, that many data bytes, then CRC.
// - Coil link addresses are zero based; coils 1-86 travel as 0-85.
// - Coil data packs the first requested coil into the least significant bit.
// - Requested coils beyond the defined range read back as 0.
// - Function 03h returns the requested count of consecutive holding registers.
// - Each register returns two bytes, high first; byte count is twice count.
// - Register link addresses are one less than the register number.
// - Broadcast coil reads and register reads are never answered.
// - Function 05h sets the coil on FF00h and clears it on 0000h.
// - Broadcast single coil writes act without any reply frame.
// - Coil read query order: address, function, start, count, CRC.
// - Register read reply order: address, function, byte count, data, CRC.
// - A successful single coil write is answered by echoing the query.
// - Failed queries answer function plus 80h followed by an exception code.
// - Every frame ends with CRC-16 over x16+x15+x2+1.
`timescale 1ns/10ps
`include "mbs_map.vh"

module mbs_func (
    input wire mclk_in,
    input wire rst_in,
    input wire [7:0] station_addr_in,
    input wire [7:0] rx_byte_in,
    input wire rx_valid_in,
    input wire rx_end_in,
    input wire tx_ready_in,
    input wire [15:0] trip_cause_code_in,
    input wire [15:0] trip_drive_state_in,
    input wire [15:0] trip_frequency_high_in,
    input wire [15:0] trip_frequency_low_in,
    input wire [15:0] trip_output_current_in,
    input wire [15:0] trip_dc_bus_voltage_in,
    output reg [7:0] tx_byte_out,
    output reg tx_valid_out,
    output reg busy_out,
    output reg [85:0] coil_state_out,
    output reg coil_write_out
);

    // Sequencer states: wait for a frame, decode it, load a reply byte, hand it over.
    localparam ST_IDLE = 2'b00;
    localparam ST_EXEC = 2'b01;
    localparam ST_LOAD = 2'b10;
    localparam ST_SEND = 2'b11;

    // Reply shapes, fixed when the query is decoded.
    localparam KIND_ECHO = 2'b00;
    localparam KIND_EXC = 2'b01;
    localparam KIND_COILS = 2'b10;
    localparam KIND_REGS = 2'b11;

    // The query stays in rx_buf until the reply is done, so an echo needs no copy.
    reg [1:0] state;
    reg [1:0] kind;
    reg [7:0] rx_buf [0:7];
    reg [3:0] rx_cnt;
    reg [15:0] rx_crc;
    reg [7:0] exc_code;
    reg [4:0] tx_len;
    reg [4:0] tx_idx;
    reg [15:0] tx_crc;
    reg [7:0] resp_byte;
    reg [15:0] reg_word;

    // One byte step of the reflected CRC-16.
    function [15:0] mbs_crc;
        input [15:0] crc;
        input [7:0] data;
        integer i;
        reg [15:0] r;
        begin
            r = crc ^ {8'h00, data};
            for (i = 0; i < 8; i = i + 1) begin
                r = r[0] ? ((r >> 1) ^ `MBS_CRC_POLY) : (r >> 1);
            end
            mbs_crc = r;
        end
    endfunction

    // Query fields in their fixed positions within the eight byte frame.
    wire [7:0] q_addr = rx_buf[0];
    wire [7:0] q_func = rx_buf[1];
    wire [15:0] q_start = {rx_buf[2], rx_buf[3]};
    wire [15:0] q_val = {rx_buf[4], rx_buf[5]};
    wire q_bcast = (q_addr == `MBS_BCAST_ADDR);
    wire [16:0] q_end = {1'b0, q_start} + {1'b0, q_val};
    wire [16:0] q_first_reg = {1'b0, q_start} + 17'h00001;
    wire [7:0] coil_bytes = ({3'b000, q_val[4:0]} + 8'h07) >> 3;
    wire [7:0] reg_bytes = {q_val[6:0], 1'b0};

    // Residual of the CRC run over data and both check bytes is zero on a good frame.
    wire frame_ok = (rx_cnt == `MBS_QUERY_LEN) && (rx_crc == 16'h0000);
    wire for_us = (q_addr == station_addr_in) || q_bcast;

    // Reply byte at the current index; the two check bytes close every reply.
    wire [4:0] data_idx = tx_idx - 5'h03;
    wire [16:0] reg_num = q_first_reg + {13'h0000, data_idx[4:1]};

    // Holding register picked by the reply index; unmapped numbers read as zero.
    always @* begin
        case (reg_num)
            `MBS_REG_TRIP_CAUSE: reg_word = trip_cause_code_in;
            `MBS_REG_TRIP_STATE: reg_word = trip_drive_state_in;
            `MBS_REG_TRIP_FREQ_HI: reg_word = trip_frequency_high_in;
            `MBS_REG_TRIP_FREQ_LO: reg_word = trip_frequency_low_in;
            `MBS_REG_TRIP_CURRENT: reg_word = trip_output_current_in;
            `MBS_REG_TRIP_DC_BUS: reg_word = trip_dc_bus_voltage_in;
            default: reg_word = 16'h0000;
        endcase
    end

    // Coil bits are gathered per bit; index kept only when inside the defined range.
    reg [7:0] coil_byte;
    integer b;
    reg [16:0] off;
    reg [16:0] cidx;
    always @* begin
        coil_byte = 8'h00;
        off = 17'h00000;
        cidx = 17'h00000;
        for (b = 0; b < 8; b = b + 1) begin
            off = {9'h000, data_idx, 3'b000} + b[16:0];
            cidx = {1'b0, q_start} + off;
            if ((off < {1'b0, q_val}) && (cidx < `MBS_COIL_COUNT_W)) begin
                coil_byte[b] = coil_state_out[cidx[6:0]];
            end
        end
    end

    // Reply byte chosen by its index and by the reply shape.
    always @* begin
        if (tx_idx == tx_len) begin
            resp_byte = tx_crc[7:0];
        end else if (tx_idx == tx_len + 5'h01) begin
            resp_byte = tx_crc[15:8];
        end else if (tx_idx == 5'h00) begin
            resp_byte = q_addr;
        end else if (tx_idx == 5'h01) begin
            resp_byte = (kind == KIND_EXC) ? (q_func | `MBS_FN_EXC_FLAG) : q_func;
        end else begin
            case (kind)
                KIND_ECHO: resp_byte = rx_buf[tx_idx[2:0]];
                KIND_EXC: resp_byte = exc_code;
                KIND_COILS: resp_byte = (tx_idx == 5'h02) ? coil_bytes : coil_byte;
                KIND_REGS: begin
                    if (tx_idx == 5'h02) begin
                        resp_byte = reg_bytes;
                    end else begin
                        resp_byte = data_idx[0] ? reg_word[7:0] : reg_word[15:8];
                    end
                end
                default: resp_byte = 8'h00;
            endcase
        end
    end

    // Query capture while idle; bytes past the eighth only mark the frame as too long.
    always @(posedge mclk_in) begin
        if (rst_in) begin
            rx_cnt <= 4'h0;
            rx_crc <= `MBS_CRC_INIT;
        end else if (state != ST_IDLE || rx_end_in) begin
            rx_cnt <= 4'h0;
            rx_crc <= `MBS_CRC_INIT;
        end else if (rx_valid_in) begin
            if (rx_cnt <= `MBS_QUERY_LEN) begin
                rx_cnt <= rx_cnt + 4'h1;
            end
            rx_crc <= mbs_crc(rx_crc, rx_byte_in);
        end
    end

    // Buffer entries are written by index; later bytes never overwrite the frame.
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : gen_buf
            always @(posedge mclk_in) begin
                if (rst_in) begin
                    rx_buf[g] <= 8'h00;
                end else if (state == ST_IDLE && rx_valid_in && !rx_end_in &&
                             rx_cnt == g) begin
                    rx_buf[g] <= rx_byte_in;
                end
            end
        end
    endgenerate

    // Command sequencer: decide, act on coils, then stream the reply byte by byte.
    // The receiver is deaf while busy, since the link is half duplex.
    always @(posedge mclk_in) begin
        if (rst_in) begin
            state <= ST_IDLE;
            kind <= KIND_ECHO;
            exc_code <= 8'h00;
            tx_len <= 5'h00;
            tx_idx <= 5'h00;
            tx_crc <= `MBS_CRC_INIT;
            tx_byte_out <= 8'h00;
            tx_valid_out <= 1'b0;
            busy_out <= 1'b0;
            coil_state_out <= `MBS_COIL_RESET;
            coil_write_out <= 1'b0;
        end else begin
            coil_write_out <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (rx_end_in && frame_ok && for_us) begin
                        state <= ST_EXEC;
                        busy_out <= 1'b1;
                    end
                end
                ST_EXEC: begin
                    tx_idx <= 5'h00;
                    tx_crc <= `MBS_CRC_INIT;
                    state <= q_bcast ? ST_IDLE : ST_LOAD;
                    busy_out <= !q_bcast;
                    case (q_func)
                        `MBS_FN_READ_COILS: begin
                            if (q_val == 16'h0000 || q_val > `MBS_COIL_READ_MAX) begin
                                kind <= KIND_EXC;
                                exc_code <= `MBS_EXC_BAD_DATA;
                                tx_len <= 5'h03;
                            end else begin
                                kind <= KIND_COILS;
                                tx_len <= 5'h03 + coil_bytes[4:0];
                            end
                        end
                        `MBS_FN_READ_REGS: begin
                            tx_len <= 5'h03;
                            kind <= KIND_EXC;
                            if (q_val == 16'h0000 || q_val > `MBS_REG_READ_MAX) begin
                                exc_code <= `MBS_EXC_BAD_DATA;
                            end else if (q_first_reg < `MBS_REG_TRIP_CAUSE ||
                                         q_end > `MBS_REG_TRIP_DC_BUS) begin
                                exc_code <= `MBS_EXC_BAD_ADDR;
                            end else begin
                                kind <= KIND_REGS;
                                tx_len <= 5'h03 + reg_bytes[4:0];
                            end
                        end
                        `MBS_FN_WRITE_COIL: begin
                            kind <= KIND_EXC;
                            tx_len <= 5'h03;
                            if ({1'b0, q_start} >= `MBS_COIL_COUNT_W) begin
                                exc_code <= `MBS_EXC_BAD_ADDR;
                            end else if (q_val == `MBS_COIL_ON_DATA ||
                                         q_val == `MBS_COIL_OFF_DATA) begin
                                coil_state_out[q_start[6:0]] <= q_val[15];
                                coil_write_out <= 1'b1;
                                kind <= KIND_ECHO;
                                tx_len <= 5'h06;
                            end else begin
                                exc_code <= `MBS_EXC_BAD_DATA;
                            end
                        end
                        default: begin
                            kind <= KIND_EXC;
                            exc_code <= `MBS_EXC_BAD_FUNC;
                            tx_len <= 5'h03;
                        end
                    endcase
                end
                ST_LOAD: begin
                    tx_byte_out <= resp_byte;
                    tx_valid_out <= 1'b1;
                    state <= ST_SEND;
                end
                ST_SEND: begin
                    if (tx_ready_in) begin
                        tx_valid_out <= 1'b0;
                        if (tx_idx < tx_len) begin
                            tx_crc <= mbs_crc(tx_crc, tx_byte_out);
                        end
                        if (tx_idx == tx_len + 5'h01) begin
                            state <= ST_IDLE;
                            busy_out <= 1'b0;
                        end else begin
                            tx_idx <= tx_idx + 5'h01;
                            state <= ST_LOAD;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    busy_out <= 1'b0;
                end
            endcase
        end
    end

endmodule

// ---- testbench/mbs_func_monitor.sv ----
// Port checker for the function handler: reply byte flow, busy framing, coil updates.
// Assumes it is bound to the handler and shares its clock and synchronous reset.
`timescale 1ns/10ps
module mbs_func_monitor (
    input wire mclk_in,
    input wire rst_in,
    input wire [7:0] station_addr_in,
    input wire rx_end_in,
    input wire tx_ready_in,
    input wire [7:0] tx_byte_out,
    input wire tx_valid_out,
    input wire busy_out,
    input wire [85:0] coil_state_out,
    input wire coil_write_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    // A reply opens two cycles after busy rises; a byte is taken on valid with ready.
    sequence s_reply_start;
        $rose(busy_out) ##2 tx_valid_out;
    endsequence
    sequence s_byte_taken;
        tx_valid_out && tx_ready_in;
    endsequence

    AST_RESET_QUIET:
    assert property (disable iff (1'b0) rst_in |=> !tx_valid_out && !busy_out
        && !coil_write_out && coil_state_out == 86'h0) else $error("not idle after reset");
    AST_TX_HOLD:
    assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_byte_out))
        else $error("reply byte dropped before taken");
    AST_TX_GAP:
    assert property (s_byte_taken |=> !tx_valid_out) else $error("no gap after byte");
    AST_TX_BUSY:
    assert property (tx_valid_out |-> busy_out) else $error("reply byte outside busy");
    AST_FIRST_ADDR:
    assert property (s_reply_start |-> tx_byte_out == station_addr_in)
        else $error("reply does not open with own address");
    AST_BUSY_CAUSE:
    assert property ($rose(busy_out) |-> $past(rx_end_in)) else $error("busy without frame end");
    AST_COIL_CAUSE:
    assert property (!$past(rst_in) && coil_state_out != $past(coil_state_out) |-> coil_write_out)
        else $error("coil changed without write pulse");
    AST_WRITE_PULSE:
    assert property (coil_write_out |=> !coil_write_out) else $error("write pulse too long");
    AST_WRITE_CAUSE:
    assert property (coil_write_out |-> $past(rx_end_in, 2) || $past(rx_end_in, 3))
        else $error("write pulse not tied to a frame end");
endmodule

bind mbs_func mbs_func_monitor mbs_func_monitor_inst (.mclk_in(mclk_in), .rst_in(rst_in),
    .station_addr_in(station_addr_in), .rx_end_in(rx_end_in), .tx_ready_in(tx_ready_in),
    .tx_byte_out(tx_byte_out), .tx_valid_out(tx_valid_out), .busy_out(busy_out),
    .coil_state_out(coil_state_out), .coil_write_out(coil_write_out));

// ---- testbench/mbs_func_tb.sv ----
// Self-checking bench: queries go out through the master model and every reply
// byte is checked, in order, against a queue of expected bytes.
`timescale 1ns/10ps
module mbs_func_tb;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] station = 8'h08;
    logic [15:0] trip [6] = '{default: 16'h0000};
    logic [7:0] tx_byte_out, rx_byte;
    logic tx_valid_out, busy_out, coil_write_out, tx_ready, rx_valid, rx_end;
    logic [85:0] coil_state_out;
    logic [85:0] coils_m = 86'h0;
    logic [7:0] exp_q[$];
    logic [7:0] rep[$];
    int mismatches = 0;
    int checked = 0;

    // Clock at 25 MHz.
    always #20 mclk_in = ~mclk_in;

    mbs_func mbs_func_inst (.mclk_in(mclk_in), .rst_in(rst_in), .station_addr_in(station),
        .rx_byte_in(rx_byte), .rx_valid_in(rx_valid), .rx_end_in(rx_end),
        .tx_ready_in(tx_ready), .trip_cause_code_in(trip[0]), .trip_drive_state_in(trip[1]),
        .trip_frequency_high_in(trip[2]), .trip_frequency_low_in(trip[3]),
        .trip_output_current_in(trip[4]), .trip_dc_bus_voltage_in(trip[5]),
        .tx_byte_out(tx_byte_out), .tx_valid_out(tx_valid_out), .busy_out(busy_out),
        .coil_state_out(coil_state_out), .coil_write_out(coil_write_out));
    mbs_master_model mm_inst (.mclk_in(mclk_in), .rx_byte_out(rx_byte),
        .rx_valid_out(rx_valid), .rx_end_out(rx_end), .tx_ready_out(tx_ready));

    task automatic chk_byte(input logic [7:0] got, exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: byte %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_coils(input logic [85:0] got, exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: coils %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic results();
        if (mismatches == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Each taken reply byte is matched to the oldest note; an unexpected byte fails.
    always @(posedge mclk_in) begin
        if (!rst_in && tx_valid_out === 1'b1 && tx_ready === 1'b1)
            chk_byte(tx_byte_out, exp_q.size() ? exp_q.pop_front() : 8'hXX);
    end

    // Sends one query; a pending reply in rep gets its check word and is queued.
    task automatic query(input logic [7:0] a, f, input logic [15:0] s, v, input logic bad);
        logic [7:0] q[$];
        logic [15:0] c;
        q = '{a, f, s[15:8], s[7:0], v[15:8], v[7:0]};
        c = mm_inst.crc16(q);
        q.push_back(c[7:0] ^ {7'h00, bad}); // A corrupted word must be ignored.
        q.push_back(c[15:8]);
        if (rep.size() > 0) begin
            c = mm_inst.crc16(rep);
            rep.push_back(c[7:0]);
            rep.push_back(c[15:8]);
            exp_q = {exp_q, rep};
        end
        rep = {};
        mm_inst.send_frame(q);
        repeat (4) @(negedge mclk_in);
        // A reply that never ends is left to the cycle ceiling, which reports it.
        while (busy_out !== 1'b0) @(negedge mclk_in);
        chk_byte(8'(exp_q.size()), 8'h00);
    endtask

    task automatic coil_wr(input logic [7:0] a, input logic [15:0] c, v);
        logic ok;
        ok = (v == 16'hFF00 || v == 16'h0000);
        if (ok) coils_m[c] = v[15];
        if (a != 8'h00 && ok) rep = '{a, 8'h05, c[15:8], c[7:0], v[15:8], v[7:0]};
        if (a != 8'h00 && !ok) rep = '{a, 8'h85, 8'h03};
        query(a, 8'h05, c, v, 1'b0);
        chk_coils(coil_state_out, coils_m);
    endtask

    task automatic coil_rd(input logic [15:0] s, n);
        logic [7:0] d;
        rep = '{8'h08, 8'h01, 8'((n + 7) / 8)};
        for (int i = 0; i < (n + 7) / 8; i++) begin
            d = 8'h00;
            for (int b = 0; b < 8; b++)
                if (i * 8 + b < n && s + i * 8 + b < 86) d[b] = coils_m[s + i * 8 + b];
            rep.push_back(d);
        end
        query(8'h08, 8'h01, s, n, 1'b0);
    endtask

    // A hang is cut short well beyond the length of the sequence below.
    initial begin
        repeat (20000) @(posedge mclk_in);
        mismatches++;
        results();
    end

    // Main sequence.
    initial begin
        void'($urandom(32'h80dd));
        repeat (2) @(posedge mclk_in);
        rst_in <= 1'b0;
        foreach (trip[i]) trip[i] <= 16'($urandom);
        @(posedge mclk_in);
        rep = '{8'h08, 8'h03, 8'h0C};
        foreach (trip[i]) rep = {rep, trip[i][15:8], trip[i][7:0]};
        query(8'h08, 8'h03, 16'h0011, 16'h0006, 1'b0);
        rep = '{8'h08, 8'h83, 8'h03};
        query(8'h08, 8'h03, 16'h0011, 16'h0007, 1'b0);
        coil_wr(8'h08, 16'h0006, 16'hFF00);
        coil_wr(8'h08, 16'h0008, 16'hFF00);
        coil_wr(8'h08, 16'h0055, 16'hFF00);
        coil_wr(8'h08, 16'h0008, 16'h1234);
        coil_rd(16'h0006, 16'h0005);
        coil_rd(16'h0000, 16'h001E);
        coil_rd(16'h0050, 16'h000A);
        rep = '{8'h08, 8'h81, 8'h03};
        query(8'h08, 8'h01, 16'h0000, 16'h0000, 1'b0);
        rep = '{8'h08, 8'h81, 8'h03};
        query(8'h08, 8'h01, 16'h0000, 16'h001F, 1'b0);
        query(8'h00, 8'h01, 16'h0000, 16'h0005, 1'b0);
        query(8'h00, 8'h03, 16'h0011, 16'h0001, 1'b0);
        coil_wr(8'h00, 16'h0003, 16'hFF00);
        query(8'h08, 8'h05, 16'h0006, 16'h0000, 1'b1);
        rep = '{8'h08, 8'h84, 8'h01};
        query(8'h08, 8'h04, 16'h0000, 16'h0001, 1'b0);
        rep = '{8'h08, 8'h85, 8'h02};
        query(8'h08, 8'h05, 16'h0056, 16'hFF00, 1'b0);
        rep = '{8'h08, 8'h83, 8'h02};
        query(8'h08, 8'h03, 16'h0010, 16'h0002, 1'b0);
        // Run command on coil number 1, sent once the link is the command source.
        coil_wr(8'h08, 16'h0000, 16'hFF00);
        repeat (4) coil_wr(8'h08, 16'($urandom % 86), $urandom % 2 ? 16'hFF00 : 16'h0000);
        coil_rd(16'($urandom % 60), 16'h001E);
        results();
    end
endmodule

// ---- testbench/mbs_master_model.sv ----
// Master side of the serial link: sends query bytes and takes reply bytes.
// Assumes the handler's byte-level receive and transmit handshakes on one clock.
`timescale 1ns/10ps
module mbs_master_model (
    input wire logic mclk_in,
    output logic [7:0] rx_byte_out = 8'h00,
    output logic rx_valid_out = 1'b0,
    output logic rx_end_out = 1'b0,
    output logic tx_ready_out = 1'b0
);
    // Random stalls on the reply side, so held bytes are exercised.
    always @(posedge mclk_in) tx_ready_out <= ($urandom % 3) != 0;

    // Frame check word, preset all ones, reflected generator.
    function automatic logic [15:0] crc16(input logic [7:0] f[$]);
        logic [15:0] c;
        c = 16'hFFFF;
        foreach (f[i]) begin
            c = c ^ {8'h00, f[i]};
            for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
        end
        return c;
    endfunction

    // Bytes go out in query order with random spacing, then the frame end.
    task automatic send_frame(input logic [7:0] f[$]);
        foreach (f[i]) begin
            @(posedge mclk_in);
            rx_byte_out <= f[i];
            rx_valid_out <= 1'b1;
            @(posedge mclk_in);
            rx_valid_out <= 1'b0;
            rx_byte_out <= ~f[i]; // Stale data must not look like the last byte.
            repeat ($urandom % 3) @(posedge mclk_in);
        end
        @(posedge mclk_in);
        rx_end_out <= 1'b1;
        @(posedge mclk_in);
        rx_end_out <= 1'b0;
    endtask
endmodule
